// *** fmalu_regs.svh ***
`ifndef FMALU_REGS_SVH
`define FMALU_REGS_SVH
// register byte addresses on the wishbone slave
`define FMALU_ADDR_CMD    8'h00
`define FMALU_ADDR_ACC    8'h04
`define FMALU_ADDR_STATUS 8'h08
`define FMALU_ADDR_MADDR  8'h0C
`define FMALU_ADDR_MDATA  8'h10
// command register fields
`define FMALU_CMD_OP_LSB  0
`define FMALU_CMD_BIT_LSB 4
`define FMALU_CMD_GO_BIT  8
// status register bit positions
`define FMALU_ST_CARRY    0
`define FMALU_ST_NIBBLE   1
`define FMALU_ST_ZERO     2
`define FMALU_ST_OVER     3
`define FMALU_ST_SCARRY   4
`define FMALU_ST_BUSY     8
// reset values and the byte clear value
`define FMALU_ACC_RST     8'h00
`define FMALU_FLAGS_RST   5'h00
`define FMALU_CLR_BYTE    8'h00
// data memory size
`define FMALU_MEM_AW      9
`endif

// *** fmalu_pkg.sv ***
package fmalu_pkg;
  // operations selected by the command register
  typedef enum logic [3:0] {
    FMALU_OP_ADC_W  = 4'h0,
    FMALU_OP_ADC_M  = 4'h1,
    FMALU_OP_ADD_W  = 4'h2,
    FMALU_OP_ADD_M  = 4'h3,
    FMALU_OP_AND_W  = 4'h4,
    FMALU_OP_AND_M  = 4'h5,
    FMALU_OP_ZERO   = 4'h6,
    FMALU_OP_BITCLR = 4'h7
  } fmalu_op_e;

  // arithmetic status flags
  typedef struct packed {
    logic signed_result_carry_flag;
    logic signed_range_exceeded_flag;
    logic zero;
    logic nibble_carry_flag;
    logic carry;
  } fmalu_flags_s;

  // result of one operation
  typedef struct packed {
    logic [7:0]   result;
    fmalu_flags_s flags;
  } fmalu_res_s;
endpackage : fmalu_pkg

// *** fmalu_core.sv ***
`timescale 1ns/100ps
`include "fmalu_regs.svh"
// combinational operation unit: sums, and, clears, flag derivation
module fmalu_core
  import fmalu_pkg::*;
(
  input  wire logic [3:0]   op_i,
  input  wire logic [7:0]   acc_i,
  input  wire logic [7:0]   mem_i,
  input  wire logic [2:0]   bit_sel_i,
  input  fmalu_flags_s      flags_i,
  output fmalu_res_s        res_o
);
  logic [4:0] low_sum;
  logic [8:0] full_sum;
  logic       cin;
  logic       ov;

  // one adder serves all four add forms
  always_comb begin
    cin = 1'b0;
    if (op_i == FMALU_OP_ADC_W || op_i == FMALU_OP_ADC_M) begin
      cin = flags_i.carry;
    end
    low_sum  = {1'b0, acc_i[3:0]} + {1'b0, mem_i[3:0]} + {4'h0, cin};
    full_sum = {1'b0, acc_i} + {1'b0, mem_i} + {8'h00, cin};
    ov       = (acc_i[7] == mem_i[7]) && (full_sum[7] != acc_i[7]);
  end

  // operation select and flag update
  always_comb begin
    res_o.flags = flags_i;
    res_o.result = mem_i;
    case (op_i)
      FMALU_OP_ADC_W, FMALU_OP_ADC_M, FMALU_OP_ADD_W, FMALU_OP_ADD_M: begin
        res_o.result                           = full_sum[7:0];
        res_o.flags.carry                      = full_sum[8];
        res_o.flags.nibble_carry_flag          = low_sum[4];
        res_o.flags.zero                       = (full_sum[7:0] == 8'h00);
        res_o.flags.signed_range_exceeded_flag = ov;
        res_o.flags.signed_result_carry_flag   = ov ^ full_sum[7];
      end
      FMALU_OP_AND_W, FMALU_OP_AND_M: begin
        res_o.result     = acc_i & mem_i;
        res_o.flags.zero = ((acc_i & mem_i) == 8'h00);
      end
      FMALU_OP_ZERO: begin
        res_o.result = `FMALU_CLR_BYTE;
      end
      FMALU_OP_BITCLR: begin
        res_o.result = mem_i & ~(8'h01 << bit_sel_i);
      end
      default: begin
        res_o.result = mem_i;
      end
    endcase
  end
endmodule : fmalu_core

// *** fmalu_top.sv ***
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "fmalu_regs.svh"
// What this block does
// - any data memory address reachable, no banking
// - add with carry into accumulator, five flags
// - add with carry into memory, five flags
// - add into accumulator, five flags
// - add into memory, five flags
// - and into accumulator, zero flag only
// - and into memory, accumulator kept, zero only
// - byte clear to zero, flags kept
// - single bit clear, other bits, flags kept
module fmalu_top
  import fmalu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o
);
  typedef enum logic [2:0] {
    FMALU_IDLE  = 3'b001,
    FMALU_READ  = 3'b010,
    FMALU_WRITE = 3'b100
  } fmalu_state_e;

  // flat data memory, one address space for every section
  logic [7:0] mem [0:(1<<`FMALU_MEM_AW)-1];

  fmalu_state_e            state, next_state;
  logic [7:0]              acc, next_acc;
  fmalu_flags_s            flags, next_flags;
  logic [`FMALU_MEM_AW-1:0] maddr, next_maddr;
  logic [3:0]              op, next_op;
  logic [2:0]              bsel, next_bsel;
  logic [7:0]              operand, next_operand;
  logic [31:0]             next_dat;
  logic                    next_ack;
  logic                    next_err;
  logic                    mem_we;
  logic [7:0]              mem_wdata;
  logic                    req;
  logic                    wr_cmd;
  fmalu_res_s              res;

  assign req    = cyc_i && stb_i && !ack_o && !err_o;
  assign wr_cmd = req && we_i && sel_i[0] && adr_i == `FMALU_ADDR_CMD
                  && dat_i[`FMALU_CMD_GO_BIT];

  fmalu_core u_core (
    .op_i      (op),
    .acc_i     (acc),
    .mem_i     (operand),
    .bit_sel_i (bsel),
    .flags_i   (flags),
    .res_o     (res)
  );

  // true when the result returns to data memory
  function automatic logic to_mem(input logic [3:0] o);
    to_mem = !(o == FMALU_OP_ADC_W || o == FMALU_OP_ADD_W || o == FMALU_OP_AND_W);
  endfunction : to_mem

  // next-state for the sequencer, registers and bus answer
  always_comb begin
    next_state   = state;
    next_acc     = acc;
    next_flags   = flags;
    next_maddr   = maddr;
    next_op      = op;
    next_bsel    = bsel;
    next_operand = operand;
    next_dat     = 32'h0000_0000;
    next_ack     = 1'b0;
    next_err     = 1'b0;
    mem_we       = 1'b0;
    mem_wdata    = 8'h00;
    case (state)
      FMALU_IDLE: begin
        if (wr_cmd) begin
          next_op    = dat_i[`FMALU_CMD_OP_LSB +: 4];
          next_bsel  = dat_i[`FMALU_CMD_BIT_LSB +: 3];
          next_state = FMALU_READ;
        end
      end
      FMALU_READ: begin
        next_operand = mem[maddr];
        next_state   = FMALU_WRITE;
      end
      FMALU_WRITE: begin
        next_flags = res.flags;
        if (to_mem(op)) begin
          mem_we    = 1'b1;
          mem_wdata = res.result;
        end else begin
          next_acc = res.result;
        end
        next_state = FMALU_IDLE;
      end
      default: begin
        next_state = FMALU_IDLE;
      end
    endcase
    // bus slave: one-cycle answer, writes ignored while busy
    if (req) begin
      next_ack = 1'b1;
      case (adr_i)
        `FMALU_ADDR_CMD: begin
          next_dat = {23'h0, state != FMALU_IDLE, 1'b0, bsel, op}; // busy at bit 8
        end
        `FMALU_ADDR_ACC: begin
          next_dat = {24'h0, acc};
          if (we_i && sel_i[0] && state == FMALU_IDLE) begin
            next_acc = dat_i[7:0];
          end
        end
        `FMALU_ADDR_STATUS: begin
          next_dat = {23'h0, state != FMALU_IDLE, 3'h0, flags};
          if (we_i && sel_i[0] && state == FMALU_IDLE) begin
            next_flags = dat_i[4:0];
          end
        end
        `FMALU_ADDR_MADDR: begin
          next_dat = {{(32-`FMALU_MEM_AW){1'b0}}, maddr};
          if (we_i && state == FMALU_IDLE) begin
            if (sel_i[0]) next_maddr[7:0] = dat_i[7:0];
            if (sel_i[1]) next_maddr[8] = dat_i[8];
          end
        end
        `FMALU_ADDR_MDATA: begin
          next_dat = {24'h0, mem[maddr]};
          if (we_i && sel_i[0] && state == FMALU_IDLE) begin
            mem_we    = 1'b1;
            mem_wdata = dat_i[7:0];
          end
        end
        default: begin
          next_ack = 1'b0;
          next_err = 1'b1;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state   <= FMALU_IDLE;
      acc     <= `FMALU_ACC_RST;
      flags   <= `FMALU_FLAGS_RST;
      maddr   <= '0;
      op      <= 4'h0;
      bsel    <= 3'h0;
      operand <= 8'h00;
      dat_o   <= 32'h0000_0000;
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
    end else begin
      state   <= next_state;
      acc     <= next_acc;
      flags   <= next_flags;
      maddr   <= next_maddr;
      op      <= next_op;
      bsel    <= next_bsel;
      operand <= next_operand;
      dat_o   <= next_dat;
      ack_o   <= next_ack;
      err_o   <= next_err;
    end
  end

  // data memory write port, not reset
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[maddr] <= mem_wdata;
    end
  end
endmodule : fmalu_top

// *** fmalu_chk_sva.sv ***
`timescale 1ns/100ps
`include "fmalu_regs.svh"
// port-level checks of the register bus answer
module fmalu_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // new request, and whether it hits a register
  logic req;
  logic hit;
  assign req = cyc_i & stb_i & ~ack_o & ~err_o;
  assign hit = adr_i inside {`FMALU_ADDR_CMD, `FMALU_ADDR_ACC, `FMALU_ADDR_STATUS,
                             `FMALU_ADDR_MADDR, `FMALU_ADDR_MDATA};
  AST_ACK_NEXT: assert property (req && hit |=> ack_o && !err_o)
    else $error("no ack after mapped request");
  AST_ERR_NEXT: assert property (req && !hit |=> err_o && !ack_o)
    else $error("no err after unmapped request");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_ERR_ONE: assert property (err_o |=> !err_o)
    else $error("err longer than one cycle");
  AST_IDLE: assert property (!(cyc_i && stb_i) |=> !ack_o && !err_o)
    else $error("answer without request");
  AST_QUIET: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  AST_ST_BITS: assert property (ack_o && !we_i && adr_i == `FMALU_ADDR_STATUS
    |-> dat_o[31:9] == 23'h0 && dat_o[7:5] == 3'h0) else $error("status spare bits set");
  AST_BYTE: assert property (ack_o && !we_i && adr_i inside {`FMALU_ADDR_ACC,
    `FMALU_ADDR_MDATA} |-> dat_o[31:8] == 24'h00_0000) else $error("byte register wide");
  COV_WRITE: cover property (ack_o && we_i && adr_i == `FMALU_ADDR_CMD);
  COV_READ: cover property (ack_o && !we_i && adr_i == `FMALU_ADDR_MDATA);
  COV_ERR: cover property (err_o);
endmodule : fmalu_chk
bind fmalu_top fmalu_chk chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o));

// *** fmalu_tb.sv ***
`timescale 1ns/100ps
`include "fmalu_regs.svh"
// compares a value with its expectation and counts both
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin fails++; \
  $display("wrong value at %0t: got %h want %h", $time, g, x); end end
module tb
  import fmalu_pkg::*;
;
  logic         clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]   adr_i = 8'h00, a, m, ea, em;
  logic [3:0]   sel_i = 4'h0, op;
  logic [31:0]  dat_i = 32'h0000_0000, dat_o, q;
  logic [8:0]   s, ma;
  logic [4:0]   h;
  logic [2:0]   b;
  logic         ack_o, err_o, e, cin, ovf;
  fmalu_flags_s st, ef;
  int           fails, n_tests, k;
  // device under test
  fmalu_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o));
  // 125 MHz clock
  always #4 clk_i = ~clk_i;
  // prints the verdict and stops
  task automatic conclude;
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // one classic bus cycle, held until ack or err
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int t;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= ad;
    dat_i <= d;
    sel_i <= 4'hf;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && t < 20);
    q = dat_o;
    e = err_o;
    if (ack_o !== 1'b1 && e !== 1'b1) fails++;
    if (ack_o !== 1'b1 && e !== 1'b1) conclude();
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // reference result of one operation
  task automatic model;
    cin = (op < 4'h2) ? st.carry : 1'b0;
    s = {1'b0, a} + {1'b0, m} + 9'(cin);
    h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + 5'(cin);
    ovf = (a[7] == m[7]) && (s[7] != a[7]);
    ea = a;
    em = m;
    ef = st;
    case (op)
      4'h0, 4'h2: ea = s[7:0];
      4'h1, 4'h3: em = s[7:0];
      4'h4: ea = a & m;
      4'h5: em = a & m;
      4'h6: em = 8'h00;
      4'h7: em[b] = 1'b0;
      default: ;
    endcase
    if (op < 4'h4) ef = {ovf ^ s[7], ovf, s[7:0] == 8'h00, h[4], s[8]};
    if (op inside {4'h4, 4'h5}) ef.zero = ((a & m) == 8'h00);
  endtask : model
  // reset, then random operations of every code
  initial begin
    k = $urandom(32'h655b);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `FMALU_ADDR_ACC, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    wb(1'b0, 8'h14, 32'h0000_0000);
    `CHK(e, 1'b1)
    for (int i = 0; i < 180; i++) begin
      op = 4'(i % 9);
      ma = 9'($urandom);
      a = 8'($urandom);
      m = 8'($urandom);
      st = 5'($urandom);
      b = 3'($urandom);
      wb(1'b1, `FMALU_ADDR_MADDR, {23'h00_0000, ma});
      wb(1'b1, `FMALU_ADDR_MDATA, {24'h00_0000, m});
      wb(1'b1, `FMALU_ADDR_ACC, {24'h00_0000, a});
      wb(1'b1, `FMALU_ADDR_STATUS, {27'h000_0000, st});
      wb(1'b1, `FMALU_ADDR_CMD, {24'h00_0001, 1'b0, b, op});
      model();
      k = 0;
      do begin
        wb(1'b0, `FMALU_ADDR_STATUS, 32'h0000_0000);
        k++;
      end while (q[8] !== 1'b0 && k < 10);
      `CHK(q[8:0], {4'h0, 5'(ef)})
      if (q[8] !== 1'b0) conclude();
      wb(1'b0, `FMALU_ADDR_CMD, 32'h0000_0000);
      `CHK(q, {24'h00_0000, 1'b0, b, op})
      wb(1'b0, `FMALU_ADDR_MADDR, 32'h0000_0000);
      `CHK(q, {23'h00_0000, ma})
      wb(1'b0, `FMALU_ADDR_ACC, 32'h0000_0000);
      `CHK(q, {24'h00_0000, ea})
      wb(1'b0, `FMALU_ADDR_MDATA, 32'h0000_0000);
      `CHK(q, {24'h00_0000, em})
    end
    conclude();
  end
endmodule : tb
